// [rtl/dfc_pkg.sv]
// Shared constants for the decimating filter control block.
package dfc_pkg;
    // ------------------------------------------------------------
    // Register byte offsets.
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CFG = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_INT_STAT = 8'h0c;
    localparam logic [7:0] ADDR_INT_MASK = 8'h10;
    localparam logic [7:0] ADDR_SCALE = 8'h14;
    // ------------------------------------------------------------
    // Configuration field positions and widths.
    // ------------------------------------------------------------
    localparam int CFG_BW_LSB = 0;
    localparam int CFG_MODE_LSB = 5;
    localparam int CFG_CPLX_BIT = 7;
    localparam int CFG_RES24_BIT = 8;
    localparam int BW_W = 5;
    localparam int CFG_W = 9;
    // Control and status bit positions.
    localparam int CTRL_ARM_BIT = 0;
    localparam int CTRL_IDLE_BIT = 1;
    localparam int ST_FAULT_BIT = 0;
    localparam int ST_ARMED_BIT = 1;
    localparam int ST_IDLE_BIT = 2;
    localparam int ST_CNT_LSB = 12;
    // Interrupt status bits.
    localparam int IRQ_FAULT_BIT = 0;
    localparam int IRQ_SYNC_BIT = 1;
    localparam int IRQ_W = 2;
    // ------------------------------------------------------------
    // Halving modes, code limits, widths and reset values.
    // ------------------------------------------------------------
    localparam logic [1:0] HALVING_DISABLED = 2'h0;
    localparam logic [1:0] HALVING_ENABLED = 2'h1;
    localparam logic [1:0] SHIFT_HALVING = 2'h2;
    localparam logic [4:0] BW_CODE_MAX = 5'h12;
    localparam int CNT_W = 20;
    localparam int IN_W = 16;
    localparam int ACC_W = 34;
    localparam int OUT_W = 24;
    localparam int OUT_GAIN = 8;
    localparam logic [CFG_W-1:0] CFG_RESET = 9'h000;
    localparam logic [IRQ_W-1:0] INT_MASK_RESET = 2'h0;
    localparam logic [31:0] SCALE_UNIT = 32'h0000_0001;
    localparam logic [31:0] SCALE_SHIFT = 32'h0000_0002;
endpackage : dfc_pkg

// [rtl/dfc_decimating_filter_control.sv]
// Decimating filter control: rate selection, shift halving, sync and setup checking.
//
// Notes on behaviour
// - Halving off: full rate at code zero, else rate over two to code minus one.
// - Halving on drops every other output sample for a further factor of two.
// - Shift halving halves rate, shifts up a quarter rate, emits real data.
// - Shift halving doubles the reported data scale value.
// - Bandwidth codes zero to eighteen accepted; each code halves bandwidth.
// - Code zero bypasses all digital filtering; analog filter limits bandwidth.
// - Passband about rate over 2.56 times two to code, around zoom center.
// - Edge factors .36, .44, .5 and .62 set the response edges.
// - Halving with code zero aliases and sets the setup fault flag.
// - Listed code, mode, format and resolution combinations are invalid.
// - Complex with shift halving is invalid, as are mode code three and codes over eighteen.
// - A decimation counter picks kept and dropped samples for every stage.
// - An armed counter sync resets the counter on next sync line rise.
// - After sync, counters stay aligned with peers sharing the clock.
// - Bandwidth changes leave the counter phase undisturbed.
// - A counter reset gives a filter transient decaying within thirty outputs.
`timescale 1ns/1ps
`default_nettype none
module dfc_decimating_filter_control (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic syncIn,
    input wire logic signed [dfc_pkg::IN_W-1:0] inI,
    input wire logic signed [dfc_pkg::IN_W-1:0] inQ,
    output logic signed [dfc_pkg::OUT_W-1:0] outI,
    output logic signed [dfc_pkg::OUT_W-1:0] outQ,
    output logic outValid,
    output logic outReal,
    output logic irq
);
    import dfc_pkg::*;

    // ------------------------------------------------------------
    // Helper functions.
    // ------------------------------------------------------------

    // Mask of the low n bits of the decimation counter.
    function automatic logic [CNT_W-1:0] lowMask(input logic [BW_W:0] n);
        lowMask = CNT_W'((21'h1 << n) - 21'h1);
    endfunction : lowMask

    // Checks a configuration word against the invalid combinations.
    function automatic logic cfgValid(input logic [CFG_W-1:0] c);
        logic [4:0] code;
        logic [1:0] mode;
        logic cplx;
        logic res24;
        code = c[CFG_BW_LSB +: BW_W];
        mode = c[CFG_MODE_LSB +: 2];
        cplx = c[CFG_CPLX_BIT];
        res24 = c[CFG_RES24_BIT];
        cfgValid = 1'b1;
        if (code > BW_CODE_MAX) begin
            cfgValid = 1'b0;
        end
        if (mode != HALVING_DISABLED && mode != HALVING_ENABLED && mode != SHIFT_HALVING) begin
            cfgValid = 1'b0;
        end
        if (code == 5'h01 && mode != HALVING_ENABLED) begin
            cfgValid = 1'b0;
        end
        if (code == 5'h00 && mode != HALVING_DISABLED) begin
            cfgValid = 1'b0;
        end
        if (cplx && code == 5'h00) begin
            cfgValid = 1'b0;
        end
        if (res24 && mode == HALVING_DISABLED && code == 5'h02) begin
            cfgValid = 1'b0;
        end
        if (res24 && code <= 5'h01) begin
            cfgValid = 1'b0;
        end
        if (cplx && mode == SHIFT_HALVING) begin
            cfgValid = 1'b0;
        end
    endfunction : cfgValid

    // ------------------------------------------------------------
    // Declarations.
    // ------------------------------------------------------------
    logic [CFG_W-1:0] cfg;
    logic fault;
    logic armed;
    logic forceIdle;
    logic [IRQ_W-1:0] intStat;
    logic [IRQ_W-1:0] intMask;
    logic [CNT_W-1:0] decCount;
    logic syncMeta;
    logic syncSafe;
    logic syncLast;
    logic syncRise;
    logic syncClr;
    logic [1:0] rotPhase;
    logic signed [ACC_W-1:0] accI;
    logic signed [ACC_W-1:0] accQ;
    logic signed [ACC_W-1:0] sumI;
    logic signed [ACC_W-1:0] sumQ;
    logic signed [ACC_W+OUT_GAIN-1:0] scaledI;
    logic signed [ACC_W+OUT_GAIN-1:0] scaledQ;
    logic [4:0] bwCode;
    logic [1:0] mode;
    logic halving;
    logic [BW_W:0] blkBits;
    logic blockEnd;
    logic keepNow;
    logic setupPhase;
    logic accessPhase;
    logic wrCfg;
    logic wrCtrl;
    logic wrIntStat;
    logic wrIntMask;
    logic mapped;
    logic faultEvent;
    logic [31:0] rdValue;
    logic [31:0] scaleValue;

    // ------------------------------------------------------------
    // APB slave decode.
    // ------------------------------------------------------------

    // Zero wait states; unmapped addresses answer with an error.
    assign setupPhase = psel & ~penable;
    assign accessPhase = psel & penable;
    assign pready = 1'b1;
    assign mapped = (paddr == ADDR_CFG) | (paddr == ADDR_CTRL) | (paddr == ADDR_STATUS)
        | (paddr == ADDR_INT_STAT) | (paddr == ADDR_INT_MASK) | (paddr == ADDR_SCALE);
    assign pslverr = accessPhase & ~mapped;
    assign wrCfg = accessPhase & pwrite & (paddr == ADDR_CFG);
    assign wrCtrl = accessPhase & pwrite & (paddr == ADDR_CTRL);
    assign wrIntStat = accessPhase & pwrite & (paddr == ADDR_INT_STAT);
    assign wrIntMask = accessPhase & pwrite & (paddr == ADDR_INT_MASK);

    // Configuration fields.
    assign bwCode = cfg[CFG_BW_LSB +: BW_W];
    assign mode = cfg[CFG_MODE_LSB +: 2];
    assign halving = (mode == HALVING_ENABLED) | (mode == SHIFT_HALVING);

    // The reported scale doubles in shift halving.
    assign scaleValue = (mode == SHIFT_HALVING) ? SCALE_SHIFT : SCALE_UNIT;

    // Read multiplexer.
    always_comb begin
        rdValue = 32'h0000_0000;
        case (paddr)
            ADDR_CFG: rdValue[CFG_W-1:0] = cfg;
            ADDR_CTRL: rdValue[CTRL_IDLE_BIT] = forceIdle;
            ADDR_STATUS: begin
                rdValue[ST_FAULT_BIT] = fault;
                rdValue[ST_ARMED_BIT] = armed;
                rdValue[ST_IDLE_BIT] = forceIdle;
                rdValue[31:ST_CNT_LSB] = decCount;
            end
            ADDR_INT_STAT: rdValue[IRQ_W-1:0] = intStat;
            ADDR_INT_MASK: rdValue[IRQ_W-1:0] = intMask;
            ADDR_SCALE: rdValue = scaleValue;
            default: rdValue = 32'h0000_0000;
        endcase
    end

    // Read data is captured in the setup cycle and stands through the access.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (setupPhase && !pwrite) begin
            prdata <= rdValue;
        end
    end

    // ------------------------------------------------------------
    // Configuration and setup fault.
    // ------------------------------------------------------------

    // Each configuration write re-evaluates the fault, so it holds until fixed.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cfg <= CFG_RESET;
            fault <= 1'b0;
        end else if (wrCfg) begin
            cfg <= pwdata[CFG_W-1:0];
            fault <= ~cfgValid(pwdata[CFG_W-1:0]);
        end
    end

    assign faultEvent = wrCfg & ~cfgValid(pwdata[CFG_W-1:0]);

    // Force idle is a plain level that software holds during sync setup.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            forceIdle <= 1'b0;
        end else if (wrCtrl) begin
            forceIdle <= pwdata[CTRL_IDLE_BIT];
        end
    end

    // ------------------------------------------------------------
    // Shared sync line and decimation counter.
    // ------------------------------------------------------------

    // Two flops bring the sync pin into the clock domain.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            syncMeta <= 1'b0;
            syncSafe <= 1'b0;
            syncLast <= 1'b0;
        end else begin
            syncMeta <= syncIn;
            syncSafe <= syncMeta;
            syncLast <= syncSafe;
        end
    end

    assign syncRise = syncSafe & ~syncLast;
    assign syncClr = armed & syncRise;

    // Arming wins over a disarm that lands in the same cycle.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            armed <= 1'b0;
        end else if (wrCtrl && pwdata[CTRL_ARM_BIT]) begin
            armed <= 1'b1;
        end else if (syncClr) begin
            armed <= 1'b0;
        end
    end

    // Free running counter; the bandwidth code never touches its phase.
    always_ff @(posedge core_clk) begin
        if (rst || syncClr) begin
            decCount <= '0;
        end else begin
            decCount <= decCount + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Stage selection from the counter.
    // ------------------------------------------------------------

    // A block spans two to code minus one samples; halving keeps every other block.
    assign blkBits = (bwCode == 5'h00) ? 6'h00 : 6'(bwCode - 5'h01);
    assign blockEnd = (decCount & lowMask(blkBits)) == lowMask(blkBits);
    assign keepNow = halving
        ? ((decCount & lowMask(6'(blkBits + 6'h01))) == lowMask(6'(blkBits + 6'h01)))
        : blockEnd;

    // ------------------------------------------------------------
    // Octave filter chain.
    // ------------------------------------------------------------

    // Boxcar averaging over each block; code zero passes samples straight.
    assign sumI = accI + ACC_W'(inI);
    assign sumQ = accQ + ACC_W'(inQ);
    assign scaledI = ($signed((ACC_W+OUT_GAIN)'(sumI)) <<< OUT_GAIN) >>> blkBits;
    assign scaledQ = ($signed((ACC_W+OUT_GAIN)'(sumQ)) <<< OUT_GAIN) >>> blkBits;

    // Accumulators restart at every block end and at a counter sync.
    always_ff @(posedge core_clk) begin
        if (rst || syncClr || blockEnd) begin
            accI <= '0;
            accQ <= '0;
        end else begin
            accI <= sumI;
            accQ <= sumQ;
        end
    end

    // Quarter rate rotation phase advances once per kept sample.
    always_ff @(posedge core_clk) begin
        if (rst || syncClr) begin
            rotPhase <= 2'h0;
        end else if (keepNow) begin
            rotPhase <= rotPhase + 2'h1;
        end
    end

    // Output register; shift halving multiplies by j^n and keeps the real part.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            outI <= '0;
            outQ <= '0;
            outValid <= 1'b0;
            outReal <= 1'b0;
        end else begin
            outValid <= keepNow & ~forceIdle;
            outReal <= (mode == SHIFT_HALVING);
            if (keepNow && mode == SHIFT_HALVING) begin
                outQ <= '0;
                case (rotPhase)
                    2'h0: outI <= OUT_W'(scaledI);
                    2'h1: outI <= OUT_W'(-scaledQ);
                    2'h2: outI <= OUT_W'(-scaledI);
                    2'h3: outI <= OUT_W'(scaledQ);
                    default: outI <= '0;
                endcase
            end else if (keepNow) begin
                outI <= OUT_W'(scaledI);
                outQ <= OUT_W'(scaledQ);
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupts.
    // ------------------------------------------------------------

    // Sticky events cleared by writing one; a new event beats the clear.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            intStat <= '0;
        end else begin
            intStat[IRQ_FAULT_BIT] <= faultEvent
                | (intStat[IRQ_FAULT_BIT] & ~(wrIntStat & pwdata[IRQ_FAULT_BIT]));
            intStat[IRQ_SYNC_BIT] <= syncClr
                | (intStat[IRQ_SYNC_BIT] & ~(wrIntStat & pwdata[IRQ_SYNC_BIT]));
        end
    end

    // Mask register.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            intMask <= INT_MASK_RESET;
        end else if (wrIntMask) begin
            intMask <= pwdata[IRQ_W-1:0];
        end
    end

    assign irq = |(intStat & intMask);

    // ------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------

    // Counter clears after a reset and after an armed sync.
    a_reset_clear: assert property (@(posedge core_clk) rst |=> decCount == '0 && !armed)
        else $error("counter or arm not cleared by reset");

    a_sync_reset: assert property (@(posedge core_clk) disable iff (rst)
        armed && syncSafe && !syncLast && !(wrCtrl && pwdata[CTRL_ARM_BIT])
        |=> decCount == '0 && !armed && intStat[IRQ_SYNC_BIT])
        else $error("armed sync did not reset counter");

    // Counter keeps counting whatever the configuration does.
    a_count_steady: assert property (@(posedge core_clk) disable iff (rst)
        !rst && !syncClr |=> decCount == $past(decCount) + 1'b1)
        else $error("decimation counter lost phase");

    // Unarmed sync edges leave the counter alone.
    a_unarmed_ignore: assert property (@(posedge core_clk) disable iff (rst)
        !rst && !armed && syncRise |=> decCount == $past(decCount) + 1'b1)
        else $error("counter moved without an armed sync");

    a_alias_fault: assert property (@(posedge core_clk) disable iff (rst)
        wrCfg && pwdata[CFG_BW_LSB +: BW_W] == 5'h00
        && pwdata[CFG_MODE_LSB +: 2] == HALVING_ENABLED |=> fault && intStat[IRQ_FAULT_BIT])
        else $error("halving at code zero did not fault");

    a_fault_hold: assert property (@(posedge core_clk) disable iff (rst)
        fault && !wrCfg |=> fault)
        else $error("setup fault dropped without a rewrite");

    a_bypass_rate: assert property (@(posedge core_clk) disable iff (rst)
        !rst && bwCode == 5'h00 && !halving && !forceIdle |=> outValid)
        else $error("code zero output not at full rate");

    a_half_drop: assert property (@(posedge core_clk) disable iff (rst)
        outValid && halving && $stable(cfg) && !syncClr |-> !keepNow)
        else $error("halving kept two adjacent samples");

    a_shift_real: assert property (@(posedge core_clk) disable iff (rst)
        outValid && $past(mode) == SHIFT_HALVING |-> outQ == '0 && outReal)
        else $error("shift halving output not real");

    a_scale_double: assert property (@(posedge core_clk) disable iff (rst)
        $rose(mode == SHIFT_HALVING) |-> scaleValue == SCALE_UNIT + SCALE_UNIT)
        else $error("scale not doubled in shift halving");

endmodule : dfc_decimating_filter_control
`default_nettype wire

// [dv/dfc_adc_model.sv]
// Model of the ADC sample stream and the shared sync line in front of the block.
`timescale 1ns/1ps
`default_nettype none
module dfc_adc_model (
    input wire logic core_clk,
    input wire logic signed [dfc_pkg::IN_W-1:0] level,
    input wire logic pulseReq,
    output logic signed [dfc_pkg::IN_W-1:0] inI,
    output logic signed [dfc_pkg::IN_W-1:0] inQ,
    output logic syncIn
);
    import dfc_pkg::*;
    // One complex sample per clock; quadrature mirrors in-phase so both lanes are checkable.
    // Samples and the sync line change just after the clock edge, like a real converter.
    always @(posedge core_clk) begin
        inI <= level;
        inQ <= -level;
        syncIn <= pulseReq;
    end
endmodule : dfc_adc_model
`default_nettype wire

// [dv/tb.sv]
// Self-checking bench for the decimating filter control block.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dfc_pkg::*;
    // ----------------------------------------------------------------
    // Signals, clock, timeout and output monitor.
    // ----------------------------------------------------------------
    typedef struct {int gap; logic signed [OUT_W-1:0] ivl;
        logic signed [OUT_W-1:0] qvl; logic re;} dfc_exp_t;
    logic core_clk, rst, psel, penable, pwrite, pulseReq, pready, pslverr;
    logic syncIn, outValid, outReal, irq, errV;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdv, cfgW;
    logic signed [IN_W-1:0] inI, inQ, level;
    logic signed [OUT_W-1:0] outI, outQ;
    int miscompares = 0;
    int n_tests = 0;
    int cyc = 0;
    int setupCyc, lastValid, nValid, s1, c1;
    dfc_exp_t expQ[$];
    logic [8:0] cfgTab[5] = '{9'h000, 9'h021, 9'h003, 9'h044, 9'h026};
    int gapTab[5] = '{1, 2, 4, 16, 64};

    dfc_decimating_filter_control uut (.core_clk(core_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .syncIn(syncIn), .inI(inI), .inQ(inQ),
        .outI(outI), .outQ(outQ), .outValid(outValid), .outReal(outReal), .irq(irq));
    dfc_adc_model adc (.core_clk(core_clk), .level(level), .pulseReq(pulseReq), .inI(inI),
        .inQ(inQ), .syncIn(syncIn));

    // Free-running clock at 25 MHz.
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // Counts cycles and cuts a hung run short.
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            miscompares++;
            complete_run();
        end
    end
    // Each output pulse takes the oldest expected note off the queue.
    always @(negedge core_clk) begin
        dfc_exp_t e;
        if (outValid === 1'b1) begin
            nValid = nValid + 1;
            if (expQ.size() > 0) begin
                e = expQ.pop_front();
                if (e.gap != 0) chk("gap", 32'(e.gap), 32'(cyc - lastValid));
                chk("outI", 32'(e.ivl), 32'((e.re && outI < 0) ? -outI : outI));
                chk("outQ", 32'(e.qvl), 32'(outQ));
                chk("outReal", 32'(e.re), 32'(outReal));
            end
            lastValid = cyc;
        end
    end
    // ----------------------------------------------------------------
    // Tasks.
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One APB transfer; holds the request until pready is seen, then idles one cycle.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rv, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        setupCyc = cyc;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] v;
        logic e;
        apb(1'b1, a, d, v, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        logic e;
        apb(1'b0, a, 32'h0000_0000, v, e);
    endtask : rd

    // Expected setup fault for a configuration word.
    function automatic logic faultOf(input logic [8:0] c);
        logic [4:0] b;
        logic [1:0] m;
        b = c[4:0];
        m = c[6:5];
        return (m == 2'h3) || (b == 5'h01 && m != HALVING_ENABLED) ||
            (b == 5'h00 && m != HALVING_DISABLED) || (c[7] && b == 5'h00) ||
            (c[8] && m == HALVING_DISABLED && b == 5'h02) || (c[8] && b <= 5'h01) ||
            (c[7] && m == SHIFT_HALVING);
    endfunction : faultOf

    // Programs a rate, lets it settle, then expects six evenly spaced outputs.
    task automatic stream(input logic [8:0] c, input int gap);
        int n;
        logic sh;
        sh = (c[6:5] == SHIFT_HALVING);
        wr(ADDR_CFG, 32'(c));
        repeat (2 * gap + 6) @(posedge core_clk);
        for (int k = 0; k < 6; k++) begin
            expQ.push_back('{(k == 0) ? 0 : gap, {level, 8'h00},
                sh ? 24'h000000 : {-level, 8'h00}, sh});
        end
        n = 0;
        while (expQ.size() > 0 && n < 20 * gap + 100) begin
            @(posedge core_clk);
            n++;
        end
        chk("pending outputs", 32'h0, 32'(expQ.size()));
        expQ.delete();
    endtask : stream

    task automatic syncPulse();
        pulseReq <= 1'b1;
        repeat (4) @(posedge core_clk);
        pulseReq <= 1'b0;
        repeat (8) @(posedge core_clk);
    endtask : syncPulse

    task automatic complete_run();
        if (miscompares == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run
    // ----------------------------------------------------------------
    // Main sequence.
    // ----------------------------------------------------------------
    initial begin
        {rst, psel, penable, pwrite, pulseReq} = 5'b10000;
        paddr = 8'h00;
        pwdata = 32'h0;
        void'($urandom(33));
        level = 16'($urandom_range(1, 32767));
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        // Reset values and an unmapped address.
        rd(ADDR_CFG, rdv);
        chk("cfg reset", 32'(CFG_RESET), rdv);
        rd(ADDR_INT_MASK, rdv);
        chk("mask reset", 32'(INT_MASK_RESET), rdv);
        rd(ADDR_SCALE, rdv);
        chk("scale reset", SCALE_UNIT, rdv);
        wr(8'h20, 32'hffff_ffff);
        apb(1'b0, 8'h20, 32'h0, rdv, errV);
        chk("unmapped data", 32'h0, rdv);
        chk("unmapped error", 32'h1, 32'(errV));
        // Random settings against the fault table, with interrupt raise, mask and clear.
        for (int k = 0; k < 40; k++) begin
            cfgW = 32'($urandom_range(0, 511));
            cfgW[4:0] = 5'($urandom_range(0, 18));
            wr(ADDR_INT_STAT, 32'h3);
            wr(ADDR_INT_MASK, 32'(k % 2));
            wr(ADDR_CFG, cfgW);
            rd(ADDR_STATUS, rdv);
            chk("fault", 32'(faultOf(cfgW[8:0])), 32'(rdv[ST_FAULT_BIT]));
            rd(ADDR_INT_STAT, rdv);
            chk("fault event", 32'(faultOf(cfgW[8:0])), rdv);
            chk("irq", 32'(faultOf(cfgW[8:0]) && k % 2), 32'(irq));
            rd(ADDR_SCALE, rdv);
            chk("scale", (cfgW[6:5] == SHIFT_HALVING) ? SCALE_SHIFT : SCALE_UNIT, rdv);
        end
        wr(ADDR_CFG, 32'h60);
        wr(ADDR_CFG, 32'h7f);
        wr(ADDR_INT_STAT, 32'h3);
        rd(ADDR_STATUS, rdv);
        chk("fault held", 32'h1, 32'(rdv[ST_FAULT_BIT]));
        // Output rate, data and real conversion for each mode.
        for (int k = 0; k < 5; k++) stream(cfgTab[k], gapTab[k]);
        // Bandwidth change keeps the counter running without a jump.
        rd(ADDR_STATUS, rdv);
        c1 = int'(rdv[31:ST_CNT_LSB]);
        s1 = setupCyc;
        wr(ADDR_CFG, 32'h005);
        rd(ADDR_STATUS, rdv);
        chk("counter phase", 32'(setupCyc - s1), 32'(int'(rdv[31:ST_CNT_LSB]) - c1));
        // Sync procedure: idle, unarmed pulse ignored, armed pulse clears the counter.
        wr(ADDR_CTRL, 32'h2);
        s1 = nValid;
        repeat (20) @(posedge core_clk);
        chk("idle outputs", 32'(s1), 32'(nValid));
        syncPulse();
        rd(ADDR_STATUS, rdv);
        chk("unarmed keeps count", 32'h1, 32'(rdv[31:ST_CNT_LSB] >= 16));
        wr(ADDR_CTRL, 32'h3);
        rd(ADDR_STATUS, rdv);
        chk("armed", 32'h6, rdv[2:0]);
        syncPulse();
        rd(ADDR_STATUS, rdv);
        chk("counter cleared", 32'h1, 32'(rdv[31:ST_CNT_LSB] < 16));
        chk("disarmed", 32'h0, 32'(rdv[ST_ARMED_BIT]));
        rd(ADDR_INT_STAT, rdv);
        chk("sync event", 32'h2, rdv & 32'h2);
        wr(ADDR_CTRL, 32'h0);
        stream(9'h003, 4);
        // Reset disarms a pending sync.
        wr(ADDR_CTRL, 32'h1);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        syncPulse();
        rd(ADDR_INT_STAT, rdv);
        chk("no sync after reset", 32'h0, rdv);
        complete_run();
    end
endmodule : tb
`default_nettype wire
